// file: fldm_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "fldm_cfg.svh"
module fldm_top import fldm_pkg::*; #(
    parameter int WIN_NS = `FLDM_WIN_NS,
    parameter int RXER_THR = `FLDM_RXER_THR,
    parameter int MLT3_THR = `FLDM_MLT3_THR,
    parameter int SNR_THR = `FLDM_SNR_THR
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hw_reset_n,
    input wire logic common_pinout_mode,
    input wire logic odd_nibble_strap,
    input wire logic link_drop_enable_strap,
    input wire logic mac_mode_strap,
    input wire logic link_up,
    input wire logic rx_error_evt,
    input wire logic mlt3_error_evt,
    input wire logic snr_cross_evt,
    input wire logic energy_lost,
    input wire logic descr_unlocked,
    input wire logic [`FLDM_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic force_link_down
);
    localparam int CLK_NS = `FLDM_CLK_NS;
    localparam int WIN_CYC = WIN_NS / CLK_NS;
    localparam int WW = $clog2(WIN_CYC);
    localparam int THRS [3] = '{RXER_THR, MLT3_THR, SNR_THR};

    // reload value from a strap set; in common pinout mode the
    // link-drop straps carry other meanings and are ignored
    function automatic logic [15:0] fldm_dflt(input logic [3:0] s);
        logic [15:0] v;
        v = `FLDM_CTL_OFF;
        if (s[`FLDM_STRAP_COMMON]) begin
            v = `FLDM_CTL_COMMON;
        end else if (!s[`FLDM_STRAP_LDEN]) begin
            v = `FLDM_CTL_OFF;
        end else if (s[`FLDM_STRAP_ODD]) begin
            v = `FLDM_CTL_ODD;
        end else if (!s[`FLDM_STRAP_MAC]) begin
            v = `FLDM_CTL_NOODD_ED;
        end else begin
            v = `FLDM_CTL_NOODD;
        end
        return v;
    endfunction

    // pin synchroniser; two flops per pin, both cleared to 0 by rstn
    logic [4:0] sy1_q;
    logic [4:0] sy2_q;
    logic [4:0] pins;
    assign pins = {hw_reset_n, mac_mode_strap, link_drop_enable_strap,
                   odd_nibble_strap, common_pinout_mode};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sy1_q <= 5'h00;
            sy2_q <= 5'h00;
        end else begin
            sy1_q <= pins;
            sy2_q <= sy1_q;
        end
    end

    logic hw_rst_s;
    assign hw_rst_s = !sy2_q[`FLDM_STRAP_HWRST];

    // reset sequencing and strap latch
    fldm_state_t st_q;
    fldm_state_t st_d;
    logic [1:0] wait_q;
    logic [1:0] wait_d;
    logic [3:0] lat_q;
    logic [3:0] lat_d;
    logic latch_por;
    logic latch_hard;

    always_comb begin
        st_d = st_q;
        wait_d = wait_q;
        lat_d = lat_q;
        latch_por = 1'b0;
        latch_hard = 1'b0;
        case (st_q)
            FLDM_ST_POR: begin
                // wait until the synchroniser holds real pin levels
                if (wait_q == `FLDM_SYNC_WAIT) begin
                    latch_por = 1'b1;
                    lat_d = sy2_q[3:0];
                    st_d = FLDM_ST_RUN;
                end else begin
                    wait_d = wait_q + 2'h1;
                end
            end
            FLDM_ST_RUN: begin
                if (hw_rst_s) begin
                    st_d = FLDM_ST_HARD;
                end
            end
            FLDM_ST_HARD: begin
                if (!hw_rst_s) begin
                    latch_hard = 1'b1;
                    lat_d = sy2_q[3:0];
                    lat_d[`FLDM_STRAP_ODD] = lat_q[`FLDM_STRAP_ODD];
                    st_d = FLDM_ST_RUN;
                end
            end
            default: begin
                st_d = FLDM_ST_POR;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= FLDM_ST_POR;
            wait_q <= 2'h0;
            lat_q <= 4'h0;
        end else begin
            st_q <= st_d;
            wait_q <= wait_d;
            lat_q <= lat_d;
        end
    end

    logic run;
    assign run = (st_q == FLDM_ST_RUN);

    // free-running 10 us window
    logic [WW-1:0] win_q;
    logic [WW-1:0] win_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        tick_d = (win_q == WW'(WIN_CYC-1));
        win_d = tick_d ? '0 : win_q + WW'(1);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            win_q <= '0;
            tick_q <= 1'b0;
        end else begin
            win_q <= win_d;
            tick_q <= tick_d;
        end
    end

    // counted criteria
    logic [2:0] evt_v;
    logic [2:0] hit_v;
    logic cnt_clr;
    assign evt_v = {snr_cross_evt, mlt3_error_evt, rx_error_evt};
    assign cnt_clr = !link_up || !run;

    for (genvar i = 0; i < 3; i++) begin : g_cnt
        fldm_win_counter #(
            .THR(THRS[i]),
            .CW($clog2(THRS[i]+1))
        ) u_cnt (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .clr(cnt_clr),
            .win_tick(tick_q),
            .evt(evt_v[i]),
            .hit(hit_v[i])
        );
    end

    // register file
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic [15:0] cfg1_q;
    logic [15:0] cfg1_d;
    logic [15:0] cfg2_q;
    logic [15:0] cfg2_d;
    logic [15:0] stat_q;
    logic [15:0] stat_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic drop_q;
    logic drop_d;
    logic [15:0] cause;
    logic arm_mlt3;
    logic arm_descr;
    logic rd_stat;
    logic sw_rst;

    // the line-code and descrambler detectors need their tuning
    // written first; until then those criteria stay quiet
    assign arm_mlt3 = (cfg1_q == `FLDM_CFG1_MLT3);
    assign arm_descr = (cfg2_q[5:0] == `FLDM_CFG2_DESCR);
    assign rd_stat = reg_rd && (reg_addr == `FLDM_ADDR_STAT);
    assign sw_rst = run && reg_wr && (reg_addr == `FLDM_ADDR_SWRST)
                    && reg_wdata[`FLDM_BIT_SWRST];

    always_comb begin
        cause = 16'h0000;
        cause[0] = ctl_q[0] && hit_v[0];
        cause[1] = ctl_q[1] && hit_v[1] && arm_mlt3;
        cause[2] = ctl_q[2] && hit_v[2];
        cause[3] = ctl_q[3] && energy_lost;
        cause[10] = ctl_q[10] && descr_unlocked && arm_descr;
        if (!run || !link_up) begin
            cause = 16'h0000;
        end
    end

    always_comb begin
        ctl_d = ctl_q;
        cfg1_d = cfg1_q;
        cfg2_d = cfg2_q;
        rdata_d = 16'h0000;
        drop_d = |cause;
        if (latch_por || latch_hard) begin
            ctl_d = fldm_dflt(lat_d);
            cfg1_d = `FLDM_CFG1_RST;
            cfg2_d = `FLDM_CFG2_RST;
        end else if (sw_rst) begin
            ctl_d = fldm_dflt(lat_q);
            cfg1_d = `FLDM_CFG1_RST;
            cfg2_d = `FLDM_CFG2_RST;
        end else if (run && reg_wr) begin
            if (reg_addr == `FLDM_ADDR_CTL3) begin
                ctl_d = reg_wdata & `FLDM_CTL_MASK;
            end else if (reg_addr == `FLDM_ADDR_CFG1) begin
                cfg1_d = reg_wdata;
            end else if (reg_addr == `FLDM_ADDR_CFG2) begin
                cfg2_d = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == `FLDM_ADDR_CTL3) begin
                rdata_d = ctl_q;
            end else if (reg_addr == `FLDM_ADDR_STAT) begin
                rdata_d = stat_q;
            end else if (reg_addr == `FLDM_ADDR_CFG1) begin
                rdata_d = cfg1_q;
            end else if (reg_addr == `FLDM_ADDR_CFG2) begin
                rdata_d = cfg2_q;
            end else begin
                rdata_d = 16'h0000;
            end
        end
        // a cause arriving in the read cycle survives the clear
        stat_d = (rd_stat ? 16'h0000 : stat_q) | cause;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= `FLDM_CTL_OFF;
            cfg1_q <= `FLDM_CFG1_RST;
            cfg2_q <= `FLDM_CFG2_RST;
            stat_q <= 16'h0000;
            rdata_q <= 16'h0000;
            drop_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            cfg1_q <= cfg1_d;
            cfg2_q <= cfg2_d;
            stat_q <= stat_d;
            rdata_q <= rdata_d;
            drop_q <= drop_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign force_link_down = drop_q;

    a_energy_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
        (run && link_up && ctl_q[3] && energy_lost) |=> (force_link_down && stat_q[3]))
        else $error("energy loss did not drop the link");

    a_drop_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
        force_link_down |-> ((stat_q & $past(cause)) == $past(cause) && $past(cause) != 0))
        else $error("drop without a recorded cause");

    a_status_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !rd_stat |=> ((stat_q & $past(stat_q)) == $past(stat_q)))
        else $error("status cause lost without a read");

    a_common_reload: assert property (@(posedge ref_clk) disable iff (!rstn)
        (sw_rst && lat_q[`FLDM_STRAP_COMMON]) |=> (ctl_q == `FLDM_CTL_COMMON))
        else $error("common mode reload wrong");

    a_ctl_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        (run && reg_wr && reg_addr == `FLDM_ADDR_CTL3 && !latch_hard)
        |=> (ctl_q == ($past(reg_wdata) & `FLDM_CTL_MASK)))
        else $error("control_three write not taken");

    a_odd_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        (st_q == FLDM_ST_HARD) |=> $stable(lat_q[`FLDM_STRAP_ODD]))
        else $error("odd-nibble strap relatched by hard reset");

    a_mlt3_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cfg1_q != `FLDM_CFG1_MLT3) |-> !cause[1])
        else $error("line-code criterion fired without tuning");

    a_window_len: assert property (@(posedge ref_clk) disable iff (!rstn)
        tick_q |-> ##[WIN_CYC:WIN_CYC] tick_q)
        else $error("window length wrong");

    a_read_once: assert property (@(posedge ref_clk) disable iff (!rstn)
        (reg_rd && reg_addr == `FLDM_ADDR_STAT) |=> (reg_rdata == $past(stat_q)))
        else $error("status read data wrong");
endmodule

// file: fldm_cfg.svh
`ifndef FLDM_CFG_SVH
`define FLDM_CFG_SVH

`define FLDM_ADDR_W 9
`define FLDM_ADDR_CTL3 9'h00B
`define FLDM_ADDR_STAT 9'h00F
`define FLDM_ADDR_CFG1 9'h117
`define FLDM_ADDR_CFG2 9'h131
`define FLDM_ADDR_SWRST 9'h01F
`define FLDM_BIT_SWRST 15

`define FLDM_CTL_MASK 16'h040F
`define FLDM_CTL_OFF 16'h0000
`define FLDM_CTL_COMMON 16'h0009
`define FLDM_CTL_ODD 16'h040D
`define FLDM_CTL_NOODD_ED 16'h0009
`define FLDM_CTL_NOODD 16'h0001

`define FLDM_CFG1_RST 16'h0000
`define FLDM_CFG1_MLT3 16'h0417
`define FLDM_CFG2_RST 16'h0000
`define FLDM_CFG2_DESCR 6'h08

`define FLDM_STRAP_COMMON 0
`define FLDM_STRAP_ODD 1
`define FLDM_STRAP_LDEN 2
`define FLDM_STRAP_MAC 3
`define FLDM_STRAP_HWRST 4
`define FLDM_SYNC_WAIT 2'h2

`define FLDM_RXER_THR 32
`define FLDM_MLT3_THR 20
`define FLDM_SNR_THR 20
`define FLDM_WIN_NS 10000
`define FLDM_CLK_NS 50

`endif

// file: fldm_pkg.sv
package fldm_pkg;
    typedef enum logic [1:0] {
        FLDM_ST_POR = 2'b00,
        FLDM_ST_RUN = 2'b01,
        FLDM_ST_HARD = 2'b10
    } fldm_state_t;
endpackage

// file: fldm_win_counter.sv
`timescale 1ns/1ns
module fldm_win_counter #(
    parameter int THR = 32,
    parameter int CW = 6
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clr,
    input wire logic win_tick,
    input wire logic evt,
    output logic hit
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic hit_q;
    logic hit_d;
    logic [CW:0] sum;

    always_comb begin
        sum = (clr || win_tick) ? '0 : {1'b0, cnt_q};
        sum = sum + {{CW{1'b0}}, evt};
        hit_d = !clr && (sum >= (CW+1)'(THR));
        // saturate so a long burst cannot wrap back below the threshold
        if (clr) begin
            cnt_d = '0;
        end else if (sum >= (CW+1)'(THR)) begin
            cnt_d = CW'(THR);
        end else begin
            cnt_d = sum[CW-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            hit_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            hit_q <= hit_d;
        end
    end

    assign hit = hit_q;

    a_count_reach: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!clr && !win_tick && cnt_q == CW'(THR-1) && evt) |=> hit_q)
        else $error("threshold reached without a hit");

    a_count_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        clr |=> (cnt_q == '0 && !hit_q))
        else $error("counter not cleared while link down");
endmodule

// file: fldm_link_partner.sv
`timescale 1ns/1ns
module fldm_link_partner (
    input wire logic ref_clk,
    output logic rx_error_evt,
    output logic mlt3_error_evt,
    output logic snr_cross_evt,
    output logic energy_lost,
    output logic descr_unlocked
);
    // one pulse line per counted fault kind: 0 rx error, 1 line code, 2 low snr
    logic [2:0] ev;
    assign rx_error_evt = ev[0];
    assign mlt3_error_evt = ev[1];
    assign snr_cross_evt = ev[2];
    initial begin
        ev <= 3'h0;
        energy_lost <= 1'b0;
        descr_unlocked <= 1'b0;
    end
    // gap lets the far side send its faults slowly as well as back to back
    task automatic burst(input int k, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            ev[k] <= 1'b1;
            repeat (gap) begin
                @(posedge ref_clk);
                ev[k] <= 1'b0;
            end
        end
        @(posedge ref_clk);
        ev[k] <= 1'b0;
    endtask
    task automatic set_energy(input logic v);
        @(posedge ref_clk);
        energy_lost <= v;
    endtask
    task automatic set_descr(input logic v);
        @(posedge ref_clk);
        descr_unlocked <= v;
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
`include "fldm_cfg.svh"
`define CHK(n, e, g) check(n, e, g)
module testbench;
    localparam int W = 40;
    localparam int LIMIT = 12000;
    logic ref_clk;
    logic rstn;
    logic hw_reset_n;
    logic common_pinout_mode;
    logic odd_nibble_strap;
    logic link_drop_enable_strap;
    logic mac_mode_strap;
    logic link_up;
    logic rx_error_evt, mlt3_error_evt, snr_cross_evt, energy_lost, descr_unlocked;
    logic [`FLDM_ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic force_link_down;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int tcount = 0;
    // strap sets as {common, odd, enable, mac} in bits 3..0
    logic [4:0] tab [5] = '{5'h1F, 5'h00, 5'h06, 5'h02, 5'h03};
    logic [15:0] tab_exp [5] = '{16'h0009, 16'h0000, 16'h040D, 16'h0009, 16'h0001};

    fldm_top #(.WIN_NS(2000), .RXER_THR(4), .MLT3_THR(3), .SNR_THR(3)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .hw_reset_n(hw_reset_n),
        .common_pinout_mode(common_pinout_mode), .odd_nibble_strap(odd_nibble_strap),
        .link_drop_enable_strap(link_drop_enable_strap), .mac_mode_strap(mac_mode_strap),
        .link_up(link_up), .rx_error_evt(rx_error_evt), .mlt3_error_evt(mlt3_error_evt),
        .snr_cross_evt(snr_cross_evt), .energy_lost(energy_lost),
        .descr_unlocked(descr_unlocked), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .force_link_down(force_link_down));

    fldm_link_partner lp (
        .ref_clk(ref_clk), .rx_error_evt(rx_error_evt), .mlt3_error_evt(mlt3_error_evt),
        .snr_cross_evt(snr_cross_evt), .energy_lost(energy_lost),
        .descr_unlocked(descr_unlocked));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // cycle count since power-on release, used to place bursts inside one window
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) cyc <= 0;
        else cyc <= cyc + 1;
    end

    always @(posedge ref_clk) begin
        tcount <= tcount + 1;
        if (tcount == LIMIT) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [8:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK($sformatf("reg %h", a), e, reg_rdata);
    endtask

    task automatic drop_chk(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (5) begin
            @(posedge ref_clk);
            #1;
            seen = seen | force_link_down;
        end
        `CHK("force_link_down", {15'h0000, e}, {15'h0000, seen});
    endtask

    task automatic align(input int off);
        do @(posedge ref_clk); while (cyc % W != off);
    endtask

    // counters saturate until the window ends, so let two windows pass;
    // a cause still standing after the last read has set the status again
    task automatic settle(input logic [15:0] left);
        repeat (2 * W) @(posedge ref_clk);
        rd(`FLDM_ADDR_STAT, left);
        rd(`FLDM_ADDR_STAT, 16'h0000);
    endtask

    task automatic do_por();
        rstn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic do_hw();
        hw_reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        hw_reset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic set_straps(input logic [4:0] s);
        common_pinout_mode <= s[3];
        odd_nibble_strap <= s[2];
        link_drop_enable_strap <= s[1];
        mac_mode_strap <= s[0];
    endtask

    initial begin
        hw_reset_n <= 1'b1;
        link_up <= 1'b1;
        reg_addr <= 9'h000;
        reg_wdata <= 16'h0000;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        set_straps(5'h1F);
        do_por();
        rd(`FLDM_ADDR_CTL3, 16'h0009);
        rd(`FLDM_ADDR_STAT, 16'h0000);
        rd(`FLDM_ADDR_CFG1, 16'h0000);
        rd(`FLDM_ADDR_CFG2, 16'h0000);
        rd(9'h055, 16'h0000);
        wr(`FLDM_ADDR_CTL3, 16'hFFFF);
        rd(`FLDM_ADDR_CTL3, 16'h040F);
        wr(`FLDM_ADDR_STAT, 16'hFFFF);
        rd(`FLDM_ADDR_STAT, 16'h0000);
        wr(`FLDM_ADDR_CTL3, 16'h0008);
        lp.set_energy(1'b1);
        drop_chk(1'b1);
        lp.set_energy(1'b0);
        repeat (4) @(posedge ref_clk);
        rd(`FLDM_ADDR_STAT, 16'h0008);
        rd(`FLDM_ADDR_STAT, 16'h0000);
        wr(`FLDM_ADDR_CTL3, 16'h0000);
        lp.set_energy(1'b1);
        drop_chk(1'b0);
        lp.set_energy(1'b0);
        wr(`FLDM_ADDR_CTL3, 16'h0001);
        align(10);
        lp.burst(0, 3, 0);
        drop_chk(1'b0);
        settle(16'h0000);
        align(34);
        lp.burst(0, 3, 0);
        align(10);
        lp.burst(0, 1, 0);
        drop_chk(1'b0);
        align(10);
        lp.burst(0, 4, 0);
        drop_chk(1'b1);
        rd(`FLDM_ADDR_STAT, 16'h0001);
        settle(16'h0001);
        link_up <= 1'b0;
        align(10);
        lp.burst(0, 4, 0);
        drop_chk(1'b0);
        link_up <= 1'b1;
        settle(16'h0000);
        wr(`FLDM_ADDR_CTL3, 16'h0002);
        align(10);
        lp.burst(1, 3, 0);
        drop_chk(1'b0);
        settle(16'h0000);
        wr(`FLDM_ADDR_CFG1, 16'h0417);
        rd(`FLDM_ADDR_CFG1, 16'h0417);
        align(10);
        lp.burst(1, 3, 0);
        drop_chk(1'b1);
        rd(`FLDM_ADDR_STAT, 16'h0002);
        settle(16'h0002);
        wr(`FLDM_ADDR_CTL3, 16'h0004);
        align(10);
        lp.burst(2, 3, 1);
        drop_chk(1'b1);
        rd(`FLDM_ADDR_STAT, 16'h0004);
        settle(16'h0004);
        wr(`FLDM_ADDR_CTL3, 16'h040F);
        lp.set_descr(1'b1);
        drop_chk(1'b0);
        wr(`FLDM_ADDR_CFG2, 16'h0008);
        drop_chk(1'b1);
        lp.set_descr(1'b0);
        repeat (4) @(posedge ref_clk);
        rd(`FLDM_ADDR_STAT, 16'h0400);
        for (int i = 0; i < 5; i++) begin
            set_straps(tab[i]);
            do_por();
            rd(`FLDM_ADDR_CTL3, tab_exp[i]);
        end
        wr(`FLDM_ADDR_CTL3, 16'h0400);
        mac_mode_strap <= 1'b0;
        wr(`FLDM_ADDR_SWRST, 16'h8000);
        rd(`FLDM_ADDR_CTL3, 16'h0001);
        do_hw();
        rd(`FLDM_ADDR_CTL3, 16'h0009);
        odd_nibble_strap <= 1'b1;
        do_hw();
        rd(`FLDM_ADDR_CTL3, 16'h0009);
        common_pinout_mode <= 1'b1;
        do_hw();
        rd(`FLDM_ADDR_CTL3, 16'h0009);
        wr(`FLDM_ADDR_CTL3, 16'h0001);
        rd(`FLDM_ADDR_CTL3, 16'h0001);
        wr(`FLDM_ADDR_SWRST, 16'h8000);
        rd(`FLDM_ADDR_CTL3, 16'h0009);
        give_verdict();
    end
endmodule
